// File: opm_ext_bus_model.sv
`timescale 1ns/1ns
`default_nettype none
module opm_ext_bus_model import opm_pkg::*; (
  // clock, reset, chosen mode
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [3:0] mode_num,
  // strap pins toward the block
  output logic [2:0] mode_select_pins,
  output logic flash_mode_pin,
  // memory side view
  input wire opm_pin_sel_t pin_sel,
  output logic [4:0] data_width
);
  // straps move only under reset, never while the device runs
  always_ff @(posedge clk_sys) begin
    if (!nrst) {flash_mode_pin, mode_select_pins} <= mode_num;
  end
  assign data_width = pin_sel.pe_data ? 5'h10 : (pin_sel.pd_data ? 5'h08 : 5'h00);
endmodule : opm_ext_bus_model
`default_nettype wire

// File: opm_pin_select.sv
`timescale 1ns/1ns
`default_nettype none
module opm_pin_select import opm_pkg::*; (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // mode pins, asynchronous
  input wire logic [2:0] mode_select_pins,
  input wire logic flash_mode_pin,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // port function selects
  output opm_pin_sel_t pin_sel
);
  logic [3:0] pins_s1_reg;
  logic [3:0] pins_s2_reg;
  logic [1:0] start_cnt_reg;
  logic [3:0] mode_bits_reg;
  opm_mode_t mode_reg;
  opm_mode_t mode_next;
  logic [7:0] port1_direction_reg;
  logic [7:0] pa_dir_reg;
  logic [7:0] pb_dir_reg;
  logic [7:0] pc_dir_reg;
  logic [7:0] area16_reg;
  logic aw_held_reg;
  logic w_held_reg;
  logic [7:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic capture;
  logic do_write;
  logic wr_hit;
  logic rd_hit;
  logic [31:0] rd_word;
  logic [4:0] stat_bits;
  opm_pin_sel_t sel_next;

  // mode pins are static by contract, but still synchronised once
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pins_s1_reg <= 4'h0;
      pins_s2_reg <= 4'h0;
    end else begin
      pins_s1_reg <= {flash_mode_pin, mode_select_pins};
      pins_s2_reg <= pins_s1_reg;
    end
  end

  // latch once after release so the mode cannot move while running
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      start_cnt_reg <= 2'h0;
    end else if (start_cnt_reg != 2'h3) begin
      start_cnt_reg <= start_cnt_reg + 2'h1;
    end
  end
  assign capture = (start_cnt_reg == OPM_CAPTURE_AT);

  always_comb begin
    case (pins_s2_reg)
      4'h1: mode_next = OPM_M1;
      4'h2: mode_next = OPM_M2;
      4'h3: mode_next = OPM_M3;
      4'h4: mode_next = OPM_M4;
      4'h5: mode_next = OPM_M5;
      4'h6, 4'hA, 4'hE: mode_next = OPM_M6;
      4'h7, 4'hB, 4'hF: mode_next = OPM_M7;
      default: mode_next = OPM_BAD;
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      mode_reg <= OPM_BAD;
      mode_bits_reg <= 4'h0;
    end else if (capture) begin
      mode_reg <= mode_next;
      mode_bits_reg <= pins_s2_reg;
    end
  end

  // write channel: address and data taken in either order
  assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
  assign s_axi_wready = !w_held_reg && !s_axi_bvalid;
  assign do_write = aw_held_reg && w_held_reg;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= OPM_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? OPM_RESP_OKAY : OPM_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_comb begin
    case (awaddr_reg)
      OPM_OFS_MODE, OPM_OFS_STAT, OPM_OFS_P1DIR, OPM_OFS_PADIR,
      OPM_OFS_PBDIR, OPM_OFS_PCDIR, OPM_OFS_AREA: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  // direction registers; the read-only words ignore writes
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      port1_direction_reg <= OPM_DIR_RST;
      pa_dir_reg <= OPM_DIR_RST;
      pb_dir_reg <= OPM_DIR_RST;
      pc_dir_reg <= OPM_DIR_RST;
    end else if (do_write && wstrb_reg[0]) begin
      case (awaddr_reg)
        OPM_OFS_P1DIR: port1_direction_reg <= wdata_reg[7:0];
        OPM_OFS_PADIR: pa_dir_reg <= wdata_reg[7:0];
        OPM_OFS_PBDIR: pb_dir_reg <= wdata_reg[7:0];
        OPM_OFS_PCDIR: pc_dir_reg <= wdata_reg[7:0];
        default: ;
      endcase
    end
  end

  // area widths: reset default depends on the mode just latched
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      area16_reg <= OPM_AREA_ALL8;
    end else if (capture) begin
      area16_reg <= (mode_next == OPM_M4) ? OPM_AREA_ALL16 : OPM_AREA_ALL8;
    end else if (do_write && wstrb_reg[0] && awaddr_reg == OPM_OFS_AREA) begin
      area16_reg <= wdata_reg[7:0];
    end
  end

  // read channel
  assign s_axi_arready = !s_axi_rvalid;
  assign stat_bits = {(mode_reg == OPM_BAD), pin_sel.bus16, pin_sel.ext_access,
                      pin_sel.adv_space, pin_sel.rom_enable};

  always_comb begin
    rd_hit = 1'b1;
    case (s_axi_araddr)
      OPM_OFS_MODE: rd_word = {24'h00_0000, OPM_MODE_RD_FIXED | {4'h0, mode_bits_reg}};
      OPM_OFS_P1DIR: rd_word = {24'h00_0000, port1_direction_reg};
      OPM_OFS_PADIR: rd_word = {24'h00_0000, pa_dir_reg};
      OPM_OFS_PBDIR: rd_word = {24'h00_0000, pb_dir_reg};
      OPM_OFS_PCDIR: rd_word = {24'h00_0000, pc_dir_reg};
      OPM_OFS_AREA: rd_word = {24'h00_0000, area16_reg};
      OPM_OFS_STAT: rd_word = {27'h000_0000, stat_bits};
      default: begin
        rd_word = 32'h0000_0000;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= OPM_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_hit ? OPM_RESP_OKAY : OPM_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // port functions from the single latched mode; unsupported codes fall to plain I/O
  always_comb begin
    sel_next = '0;
    sel_next.bus16 = |area16_reg;
    case (mode_reg)
      OPM_M1: begin
        sel_next.ext_access = 1'b1;
        sel_next.pb_addr = 8'hFF;
        sel_next.pc_addr = 8'hFF;
      end
      OPM_M2: begin
        sel_next.rom_enable = 1'b1;
        sel_next.ext_access = 1'b1;
        sel_next.pb_addr = pb_dir_reg;
        sel_next.pc_addr = pc_dir_reg;
      end
      OPM_M4, OPM_M5: begin
        sel_next.adv_space = 1'b1;
        sel_next.ext_access = 1'b1;
        sel_next.p1_addr = port1_direction_reg[3:0];
        sel_next.pa_addr = 4'hF;
        sel_next.pb_addr = 8'hFF;
        sel_next.pc_addr = 8'hFF;
      end
      OPM_M6: begin
        sel_next.rom_enable = 1'b1;
        sel_next.adv_space = 1'b1;
        sel_next.ext_access = 1'b1;
        sel_next.p1_addr = port1_direction_reg[3:0];
        sel_next.pa_addr = pa_dir_reg[3:0];
        sel_next.pb_addr = pb_dir_reg;
        sel_next.pc_addr = pc_dir_reg;
      end
      OPM_M7: begin
        sel_next.rom_enable = 1'b1;
        sel_next.adv_space = 1'b1;
      end
      OPM_M3: sel_next.rom_enable = 1'b1;
      default: sel_next.bus16 = 1'b0;
    endcase
    if (!sel_next.ext_access) begin
      sel_next.bus16 = 1'b0;
    end
    sel_next.pd_data = sel_next.ext_access;
    sel_next.pe_data = sel_next.ext_access && sel_next.bus16;
    sel_next.pf_ctrl_hi = sel_next.ext_access;
    // unsupported codes leave every port as plain I/O, so port F low pins stay off too
    sel_next.pf_lo_present = !(mode_reg == OPM_M3 || mode_reg == OPM_M7 ||
                               mode_reg == OPM_BAD);
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pin_sel <= '0;
    end else begin
      pin_sel <= sel_next;
    end
  end
endmodule : opm_pin_select
`default_nettype wire

// File: opm_pin_select_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module opm_pin_select_monitor import opm_pkg::*; (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // register bus answers
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // port function selects
  input wire opm_pin_sel_t pin_sel
);
  logic [2:0] cnt_reg;
  // saturating age since reset, keeps the mode capture out of the change check
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) cnt_reg <= 3'h0;
    else if (cnt_reg != 3'h7) cnt_reg <= cnt_reg + 3'h1;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  chk_single_chip: assert property (!pin_sel.ext_access |-> !pin_sel.pf_lo_present
    && pin_sel.p1_addr == 4'h0 && pin_sel.pc_addr == 8'h00 && !pin_sel.bus16 && !pin_sel.pd_data)
    else $error("single-chip mode drives bus pins");
  chk_rom_off_addr: assert property (!pin_sel.rom_enable && pin_sel.adv_space |->
    pin_sel.pa_addr == 4'hF && pin_sel.pb_addr == 8'hFF && pin_sel.pc_addr == 8'hFF)
    else $error("address ports not driven with rom off");
  chk_ext_ctrl: assert property (pin_sel.adv_space && pin_sel.ext_access |->
    pin_sel.pd_data && pin_sel.pf_ctrl_hi && pin_sel.pf_lo_present)
    else $error("expanded mode lacks data or control pins");
  chk_wide_data: assert property (pin_sel.pe_data |-> pin_sel.bus16 && pin_sel.pd_data)
    else $error("upper data port without wide bus");
  chk_sel_cause: assert property ($changed(pin_sel) && cnt_reg == 3'h7 |->
    $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
    else $error("pin selects moved without a register write");
  chk_p1_inputs: assert property (cnt_reg != 3'h7 |-> pin_sel.p1_addr == 4'h0)
    else $error("port 1 address out right after reset");
  chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  chk_b_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
endmodule : opm_pin_select_monitor
`default_nettype wire

// File: opm_pin_select_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module opm_pin_select_tb_top import opm_pkg::*; ();
  logic clk_sys, nrst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, flash_mode_pin;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb, mode_num;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [2:0] mode_select_pins;
  logic [4:0] data_width;
  opm_pin_sel_t pin_sel;
  int num_errors = 0, checked = 0, cyc = 0;
  integer seed = 26852;
  logic [3:0] modes [8] = '{4'h4, 4'h5, 4'h6, 4'h7, 4'hA, 4'hB, 4'hE, 4'hF};
  opm_pin_select DUT (.clk_sys(clk_sys), .nrst(nrst), .mode_select_pins(mode_select_pins),
    .flash_mode_pin(flash_mode_pin), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .pin_sel(pin_sel));
  opm_ext_bus_model u_ext (.clk_sys(clk_sys), .nrst(nrst), .mode_num(mode_num),
    .mode_select_pins(mode_select_pins), .flash_mode_pin(flash_mode_pin), .pin_sel(pin_sel),
    .data_width(data_width));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      complete_run;
    end
  end
  task complete_run;
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : complete_run
  task chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  // decisions are taken on the falling edge so ready and valid have settled
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic da, dw, db;
    db = 1'b0;
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!db) begin
      @(negedge clk_sys);
      da = s_axi_awvalid && s_axi_awready;
      dw = s_axi_wvalid && s_axi_wready;
      db = s_axi_bvalid;
      if (db) chk({30'h0, s_axi_bresp}, {30'h0, OPM_RESP_OKAY});
      @(posedge clk_sys);
      if (da) s_axi_awvalid <= 1'b0;
      if (dw) s_axi_wvalid <= 1'b0;
      if (db) s_axi_bready <= 1'b0;
    end
  endtask : wr
  task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ta, dr;
    dr = 1'b0;
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!dr) begin
      @(negedge clk_sys);
      ta = s_axi_arvalid && s_axi_arready;
      dr = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge clk_sys);
      if (ta) s_axi_arvalid <= 1'b0;
      if (dr) s_axi_rready <= 1'b0;
    end
  endtask : rd
  function automatic opm_pin_sel_t exp_sel(input logic [3:0] m, input logic [7:0] p1, pa, pb,
    input logic [7:0] pc, ar);
    opm_pin_sel_t e;
    logic [3:0] c;
    // boot and user-program modes fold onto 6 and 7
    c = m[3] ? {3'b011, m[0]} : m;
    e = '0;
    e.adv_space = 1'b1;
    e.rom_enable = c[1];
    e.ext_access = (c != 4'h7);
    if (c != 4'h7) begin
      e.bus16 = (ar != 8'h00);
      e.p1_addr = p1[3:0];
      e.pa_addr = (c == 4'h6) ? pa[3:0] : 4'hF;
      e.pb_addr = (c == 4'h6) ? pb : 8'hFF;
      e.pc_addr = (c == 4'h6) ? pc : 8'hFF;
      e.pd_data = 1'b1;
      e.pe_data = e.bus16;
      e.pf_ctrl_hi = 1'b1;
      e.pf_lo_present = 1'b1;
    end
    return e;
  endfunction : exp_sel
  task look(input logic [3:0] m, input logic [7:0] p1, pa, pb, pc, ar);
    opm_pin_sel_t e;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    e = exp_sel(m, p1, pa, pb, pc, ar);
    chk(pin_sel, e);
    chk({27'h0, data_width}, e.pe_data ? 32'h10 : (e.pd_data ? 32'h8 : 32'h0));
  endtask : look
  task run_mode(input logic [3:0] m);
    logic [31:0] v, w, d;
    logic [1:0] r;
    logic [7:0] ar;
    mode_num <= m;
    nrst <= 1'b0;
    repeat (16) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (6) @(posedge clk_sys);
    ar = (m == 4'h4) ? OPM_AREA_ALL16 : OPM_AREA_ALL8;
    rd(OPM_OFS_MODE, d, r);
    chk(d, {24'h0, OPM_MODE_RD_FIXED | {4'h0, m}});
    look(m, OPM_DIR_RST, OPM_DIR_RST, OPM_DIR_RST, OPM_DIR_RST, ar);
    if (m == 4'h4) begin
      ar = OPM_AREA_ALL8;
      wr(OPM_OFS_AREA, {24'h0, ar});
      look(m, OPM_DIR_RST, OPM_DIR_RST, OPM_DIR_RST, OPM_DIR_RST, ar);
    end
    v = $random(seed);
    w = $random(seed);
    ar = v[31:24];
    wr(OPM_OFS_P1DIR, {24'h0, v[7:0]});
    wr(OPM_OFS_PADIR, {24'h0, v[15:8]});
    wr(OPM_OFS_PBDIR, {24'h0, v[23:16]});
    wr(OPM_OFS_PCDIR, {24'h0, w[7:0]});
    wr(OPM_OFS_AREA, {24'h0, ar});
    look(m, v[7:0], v[15:8], v[23:16], w[7:0], ar);
    rd(8'h1C, d, r);
    chk({30'h0, r}, {30'h0, OPM_RESP_SLVERR});
    chk(d, 32'h0);
    $display("test of mode %0d done", m);
  endtask : run_mode
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_awaddr = '0;
    s_axi_araddr = '0;
    s_axi_wdata = '0;
    s_axi_wstrb = 4'hF;
    nrst = 1'b0;
    mode_num = 4'h4;
    foreach (modes[i]) run_mode(modes[i]);
    complete_run;
  end
endmodule : opm_pin_select_tb_top
bind opm_pin_select opm_pin_select_monitor u_mon (.clk_sys(clk_sys), .nrst(nrst),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .pin_sel(pin_sel));
`default_nettype wire

// File: opm_pkg.sv
package opm_pkg;
  localparam logic [7:0] OPM_OFS_MODE = 8'h00;
  localparam logic [7:0] OPM_OFS_P1DIR = 8'h04;
  localparam logic [7:0] OPM_OFS_PADIR = 8'h08;
  localparam logic [7:0] OPM_OFS_PBDIR = 8'h0C;
  localparam logic [7:0] OPM_OFS_PCDIR = 8'h10;
  localparam logic [7:0] OPM_OFS_AREA = 8'h14;
  localparam logic [7:0] OPM_OFS_STAT = 8'h18;
  localparam logic [7:0] OPM_MODE_RD_FIXED = 8'h80;
  localparam logic [7:0] OPM_AREA_ALL16 = 8'hFF;
  localparam logic [7:0] OPM_AREA_ALL8 = 8'h00;
  localparam logic [7:0] OPM_DIR_RST = 8'h00;
  localparam logic [1:0] OPM_CAPTURE_AT = 2'h2;
  localparam logic [1:0] OPM_RESP_OKAY = 2'b00;
  localparam logic [1:0] OPM_RESP_SLVERR = 2'b10;
  localparam int OPM_STAT_ROM = 0;
  localparam int OPM_STAT_ADV = 1;
  localparam int OPM_STAT_EXT = 2;
  localparam int OPM_STAT_BUS16 = 3;
  localparam int OPM_STAT_BAD = 4;

  typedef enum logic [7:0] {
    OPM_M1 = 8'b0000_0001,
    OPM_M2 = 8'b0000_0010,
    OPM_M3 = 8'b0000_0100,
    OPM_M4 = 8'b0000_1000,
    OPM_M5 = 8'b0001_0000,
    OPM_M6 = 8'b0010_0000,
    OPM_M7 = 8'b0100_0000,
    OPM_BAD = 8'b1000_0000
  } opm_mode_t;

  typedef struct packed {
    logic rom_enable;
    logic adv_space;
    logic ext_access;
    logic bus16;
    logic [3:0] p1_addr;
    logic [3:0] pa_addr;
    logic [7:0] pb_addr;
    logic [7:0] pc_addr;
    logic pd_data;
    logic pe_data;
    logic pf_ctrl_hi;
    logic pf_lo_present;
  } opm_pin_sel_t;
endpackage : opm_pkg
